// >>> pkg/edge_irq_pkg.sv
// shared constants for the edge interrupt and event unit
// assumes one system clock, a synchronous active-low reset and a word-wide Avalon-MM register bus
package edge_irq_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int unsigned NUM_LINES = 25;
  localparam int unsigned NUM_PIN_LINES = 16;
  localparam int unsigned NUM_INT_LINES = 9;
  localparam int unsigned NUM_DIRECT_PIN_IRQ = 5;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_IRQ_MASK = 8'h00;
  localparam logic [7:0] OFS_EVT_MASK = 8'h04;
  localparam logic [7:0] OFS_RISE_EN = 8'h08;
  localparam logic [7:0] OFS_FALL_EN = 8'h0c;
  localparam logic [7:0] OFS_SOFT_TRIG = 8'h10;
  localparam logic [7:0] OFS_PENDING = 8'h14;

  // ----------------------------------------------------------------
  // reset values and bus constants
  // ----------------------------------------------------------------
  localparam logic [24:0] RST_IRQ_MASK = 25'h0000000;
  localparam logic [24:0] RST_EVT_MASK = 25'h0000000;
  localparam logic [24:0] RST_RISE_EN = 25'h0000000;
  localparam logic [24:0] RST_FALL_EN = 25'h0000000;
  localparam logic [24:0] RST_SOFT_TRIG = 25'h0000000;
  localparam logic [24:0] RST_PENDING = 25'h0000000;
  localparam logic [3:0] FULL_WORD_BE = 4'hf;

  // ----------------------------------------------------------------
  // channel positions
  // ----------------------------------------------------------------
  localparam int unsigned CH_LOW_VOLTAGE = 16;
  localparam int unsigned CH_RTC_ALARM = 17;
  localparam int unsigned CH_BUS0_WAKE = 18;
  localparam int unsigned CH_BUS1_WAKE = 19;
  localparam int unsigned CH_COMPARATOR = 20;
  localparam int unsigned CH_OVER_VOLTAGE = 24;
  localparam int unsigned GRP_A_LO = 5;
  localparam int unsigned GRP_A_HI = 9;
  localparam int unsigned GRP_B_LO = 10;
  localparam int unsigned GRP_B_HI = 15;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SEL_IRQ_MASK,
    SEL_EVT_MASK,
    SEL_RISE_EN,
    SEL_FALL_EN,
    SEL_SOFT_TRIG,
    SEL_PENDING,
    SEL_NONE
  } reg_sel_e;

  typedef enum logic {
    BUS_IDLE,
    BUS_ACK
  } bus_state_e;

endpackage

// >>> verilog/edge_detector_bank.sv
// synchroniser and edge detector for a bank of trigger lines
// assumes lines may come from outside the system clock domain
`timescale 1ns/1ps

module edge_detector_bank #(
  parameter int unsigned WIDTH = 25
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] line_in,
  output logic [WIDTH-1:0] rise_pulse,
  output logic [WIDTH-1:0] fall_pulse
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] prev_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_next;
  logic [WIDTH-1:0] prev_next;

  // ----------------------------------------------------------------
  // sampling
  // ----------------------------------------------------------------
  always_comb begin
    meta_next = line_in;
    sync_next = meta_reg;
    prev_next = sync_reg;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
    end
  end

  // ----------------------------------------------------------------
  // edges
  // ----------------------------------------------------------------
  // one pulse per transition, from two settled samples only
  assign rise_pulse = sync_reg & ~prev_reg;
  assign fall_pulse = ~sync_reg & prev_reg;

endmodule

// >>> verilog/edge_irq_event_unit.sv
// edge interrupt and event unit: detectors, masks, pending flags, request lines
// assumes an Avalon-MM master on the system clock and asynchronous trigger lines
//
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps

module edge_irq_event_unit
  import edge_irq_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [DATA_W-1:0] readdata,
  output logic waitrequest,
  input wire logic [NUM_PIN_LINES-1:0] pin_lines,
  input wire logic [NUM_INT_LINES-1:0] internal_lines,
  output logic [NUM_DIRECT_PIN_IRQ-1:0] irq_pin_direct,
  output logic irq_pins_5_9,
  output logic irq_pins_10_15,
  output logic irq_low_voltage,
  output logic irq_bus0_wake,
  output logic irq_bus1_wake,
  output logic irq_comparator,
  output logic irq_over_voltage,
  output logic [NUM_LINES-1:0] event_lines,
  output logic event_to_core,
  output logic wakeup_req
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic reg_sel_e decode_reg(input logic [ADDR_W-1:0] addr);
    reg_sel_e sel;
    sel = SEL_NONE;
    case (addr)
      OFS_IRQ_MASK: sel = SEL_IRQ_MASK;
      OFS_EVT_MASK: sel = SEL_EVT_MASK;
      OFS_RISE_EN: sel = SEL_RISE_EN;
      OFS_FALL_EN: sel = SEL_FALL_EN;
      OFS_SOFT_TRIG: sel = SEL_SOFT_TRIG;
      OFS_PENDING: sel = SEL_PENDING;
      default: sel = SEL_NONE;
    endcase
    return sel;
  endfunction

  function automatic logic any_in_range(input logic [NUM_LINES-1:0] v,
                                        input int unsigned lo,
                                        input int unsigned hi);
    logic acc;
    acc = 1'b0;
    for (int unsigned i = 0; i < NUM_LINES; i++) begin
      if (i >= lo && i <= hi) begin
        acc = acc | v[i];
      end
    end
    return acc;
  endfunction

  // ----------------------------------------------------------------
  // edge detection
  // ----------------------------------------------------------------
  logic [NUM_LINES-1:0] all_lines;
  logic [NUM_LINES-1:0] rise_pulse;
  logic [NUM_LINES-1:0] fall_pulse;

  // no pin select muxing here; all 16 pin lines arrive, below the 9 internal lines
  assign all_lines = {internal_lines, pin_lines};

  edge_detector_bank #(
    .WIDTH(NUM_LINES)
  ) detectors (
    .clock(clock),
    .rst_n(rst_n),
    .line_in(all_lines),
    .rise_pulse(rise_pulse),
    .fall_pulse(fall_pulse)
  );

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  bus_state_e state_reg;
  bus_state_e state_next;
  logic waitrequest_reg;
  logic waitrequest_next;
  logic [DATA_W-1:0] readdata_reg;
  logic [DATA_W-1:0] readdata_next;
  logic wr_fire;
  reg_sel_e req_sel;

  logic [NUM_LINES-1:0] irq_mask_bits_reg;
  logic [NUM_LINES-1:0] evt_mask_bits_reg;
  logic [NUM_LINES-1:0] rise_enable_bits_reg;
  logic [NUM_LINES-1:0] fall_enable_bits_reg;
  logic [NUM_LINES-1:0] soft_trigger_bits_reg;
  logic [NUM_LINES-1:0] pending_flag_reg;

  assign req_sel = decode_reg(address);

  always_comb begin
    state_next = state_reg;
    waitrequest_next = 1'b1;
    readdata_next = readdata_reg;
    wr_fire = 1'b0;
    case (state_reg)
      BUS_IDLE: begin
        if (read || write) begin
          state_next = BUS_ACK;
          waitrequest_next = 1'b0;
          if (read) begin
            readdata_next = '0;
            case (req_sel)
              SEL_IRQ_MASK: readdata_next[NUM_LINES-1:0] = irq_mask_bits_reg;
              SEL_EVT_MASK: readdata_next[NUM_LINES-1:0] = evt_mask_bits_reg;
              SEL_RISE_EN: readdata_next[NUM_LINES-1:0] = rise_enable_bits_reg;
              SEL_FALL_EN: readdata_next[NUM_LINES-1:0] = fall_enable_bits_reg;
              SEL_SOFT_TRIG: readdata_next[NUM_LINES-1:0] = soft_trigger_bits_reg;
              SEL_PENDING: readdata_next[NUM_LINES-1:0] = pending_flag_reg;
              default: readdata_next = '0;
            endcase
          end
        end
      end
      BUS_ACK: begin
        // the edge that sees waitrequest low is the one that commits
        state_next = BUS_IDLE;
        wr_fire = write && (byteenable == FULL_WORD_BE);
      end
      default: begin
        state_next = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg <= BUS_IDLE;
      waitrequest_reg <= 1'b1;
      readdata_reg <= '0;
    end else begin
      state_reg <= state_next;
      waitrequest_reg <= waitrequest_next;
      readdata_reg <= readdata_next;
    end
  end

  // ----------------------------------------------------------------
  // configuration and trigger logic
  // ----------------------------------------------------------------
  logic [NUM_LINES-1:0] irq_mask_bits_next;
  logic [NUM_LINES-1:0] evt_mask_bits_next;
  logic [NUM_LINES-1:0] rise_enable_bits_next;
  logic [NUM_LINES-1:0] fall_enable_bits_next;
  logic [NUM_LINES-1:0] soft_trigger_bits_next;
  logic [NUM_LINES-1:0] pending_flag_next;
  logic [NUM_LINES-1:0] soft_pulse_reg;
  logic [NUM_LINES-1:0] soft_pulse_next;
  logic [NUM_LINES-1:0] event_lines_reg;
  logic [NUM_LINES-1:0] event_lines_next;
  logic [NUM_LINES-1:0] hw_trigger;
  logic [NUM_LINES-1:0] trigger;
  logic [NUM_LINES-1:0] pend_clear;
  logic [NUM_LINES-1:0] wr_bits;

  always_comb begin
    wr_bits = writedata[NUM_LINES-1:0];
    irq_mask_bits_next = irq_mask_bits_reg;
    evt_mask_bits_next = evt_mask_bits_reg;
    rise_enable_bits_next = rise_enable_bits_reg;
    fall_enable_bits_next = fall_enable_bits_reg;
    soft_trigger_bits_next = soft_trigger_bits_reg;
    soft_pulse_next = '0;
    pend_clear = '0;
    if (wr_fire) begin
      case (req_sel)
        SEL_IRQ_MASK: irq_mask_bits_next = wr_bits;
        SEL_EVT_MASK: evt_mask_bits_next = wr_bits;
        SEL_RISE_EN: rise_enable_bits_next = wr_bits;
        SEL_FALL_EN: fall_enable_bits_next = wr_bits;
        SEL_SOFT_TRIG: begin
          soft_trigger_bits_next = wr_bits;
          soft_pulse_next = wr_bits;
        end
        SEL_PENDING: pend_clear = wr_bits;
        default: pend_clear = '0;
      endcase
    end
    // per-bit masks keep every channel apart from its neighbours
    hw_trigger = (rise_pulse & rise_enable_bits_reg)
               | (fall_pulse & fall_enable_bits_reg);
    trigger = hw_trigger | soft_pulse_reg;
    // a new trigger beats a clear in the same cycle
    pending_flag_next = (pending_flag_reg & ~pend_clear)
                      | (trigger & irq_mask_bits_reg);
    event_lines_next = trigger & evt_mask_bits_reg;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_mask_bits_reg <= RST_IRQ_MASK;
      evt_mask_bits_reg <= RST_EVT_MASK;
      rise_enable_bits_reg <= RST_RISE_EN;
      fall_enable_bits_reg <= RST_FALL_EN;
      soft_trigger_bits_reg <= RST_SOFT_TRIG;
      pending_flag_reg <= RST_PENDING;
      soft_pulse_reg <= '0;
      event_lines_reg <= '0;
    end else begin
      irq_mask_bits_reg <= irq_mask_bits_next;
      evt_mask_bits_reg <= evt_mask_bits_next;
      rise_enable_bits_reg <= rise_enable_bits_next;
      fall_enable_bits_reg <= fall_enable_bits_next;
      soft_trigger_bits_reg <= soft_trigger_bits_next;
      pending_flag_reg <= pending_flag_next;
      soft_pulse_reg <= soft_pulse_next;
      event_lines_reg <= event_lines_next;
    end
  end

  // ----------------------------------------------------------------
  // request lines
  // ----------------------------------------------------------------
  // computed from next state so requests line up with the pending flags
  logic [NUM_LINES-1:0] live_next;
  logic [NUM_DIRECT_PIN_IRQ-1:0] irq_pin_direct_reg;
  logic [NUM_DIRECT_PIN_IRQ-1:0] irq_pin_direct_next;
  logic irq_pins_5_9_reg;
  logic irq_pins_5_9_next;
  logic irq_pins_10_15_reg;
  logic irq_pins_10_15_next;
  logic irq_low_voltage_reg;
  logic irq_low_voltage_next;
  logic irq_bus0_wake_reg;
  logic irq_bus0_wake_next;
  logic irq_bus1_wake_reg;
  logic irq_bus1_wake_next;
  logic irq_comparator_reg;
  logic irq_comparator_next;
  logic irq_over_voltage_reg;
  logic irq_over_voltage_next;
  logic event_to_core_reg;
  logic event_to_core_next;
  logic wakeup_req_reg;
  logic wakeup_req_next;

  always_comb begin
    live_next = pending_flag_next & irq_mask_bits_next;
    irq_pin_direct_next = live_next[NUM_DIRECT_PIN_IRQ-1:0];
    irq_pins_5_9_next = any_in_range(live_next, GRP_A_LO, GRP_A_HI);
    irq_pins_10_15_next = any_in_range(live_next, GRP_B_LO, GRP_B_HI);
    irq_low_voltage_next = live_next[CH_LOW_VOLTAGE];
    irq_bus0_wake_next = live_next[CH_BUS0_WAKE];
    irq_bus1_wake_next = live_next[CH_BUS1_WAKE];
    irq_comparator_next = live_next[CH_COMPARATOR];
    irq_over_voltage_next = live_next[CH_OVER_VOLTAGE];
    event_to_core_next = |event_lines_next;
    // no clock gating here, so a sleeping core still sees this level
    wakeup_req_next = (|live_next) | (|event_lines_next);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_pin_direct_reg <= '0;
      irq_pins_5_9_reg <= 1'b0;
      irq_pins_10_15_reg <= 1'b0;
      irq_low_voltage_reg <= 1'b0;
      irq_bus0_wake_reg <= 1'b0;
      irq_bus1_wake_reg <= 1'b0;
      irq_comparator_reg <= 1'b0;
      irq_over_voltage_reg <= 1'b0;
      event_to_core_reg <= 1'b0;
      wakeup_req_reg <= 1'b0;
    end else begin
      irq_pin_direct_reg <= irq_pin_direct_next;
      irq_pins_5_9_reg <= irq_pins_5_9_next;
      irq_pins_10_15_reg <= irq_pins_10_15_next;
      irq_low_voltage_reg <= irq_low_voltage_next;
      irq_bus0_wake_reg <= irq_bus0_wake_next;
      irq_bus1_wake_reg <= irq_bus1_wake_next;
      irq_comparator_reg <= irq_comparator_next;
      irq_over_voltage_reg <= irq_over_voltage_next;
      event_to_core_reg <= event_to_core_next;
      wakeup_req_reg <= wakeup_req_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign readdata = readdata_reg;
  assign waitrequest = waitrequest_reg;
  assign irq_pin_direct = irq_pin_direct_reg;
  assign irq_pins_5_9 = irq_pins_5_9_reg;
  assign irq_pins_10_15 = irq_pins_10_15_reg;
  assign irq_low_voltage = irq_low_voltage_reg;
  assign irq_bus0_wake = irq_bus0_wake_reg;
  assign irq_bus1_wake = irq_bus1_wake_reg;
  assign irq_comparator = irq_comparator_reg;
  assign irq_over_voltage = irq_over_voltage_reg;
  assign event_lines = event_lines_reg;
  assign event_to_core = event_to_core_reg;
  assign wakeup_req = wakeup_req_reg;

endmodule

// >>> verification/edge_irq_chk.sv
// checker for the edge interrupt and event unit, bound onto its top module
// assumes one clock and the synchronous active-low reset of the unit
`timescale 1ns/1ps

module edge_irq_chk
  import edge_irq_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [DATA_W-1:0] readdata,
  input wire logic waitrequest,
  input wire logic [NUM_PIN_LINES-1:0] pin_lines,
  input wire logic [NUM_INT_LINES-1:0] internal_lines,
  input wire logic [NUM_DIRECT_PIN_IRQ-1:0] irq_pin_direct,
  input wire logic irq_pins_5_9,
  input wire logic irq_pins_10_15,
  input wire logic irq_low_voltage,
  input wire logic irq_bus0_wake,
  input wire logic irq_bus1_wake,
  input wire logic irq_comparator,
  input wire logic irq_over_voltage,
  input wire logic [NUM_LINES-1:0] event_lines,
  input wire logic event_to_core,
  input wire logic wakeup_req
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  wire commit = write && !waitrequest;
  wire req = read || write;
  wire [11:0] irqv = {irq_over_voltage, irq_comparator, irq_bus1_wake, irq_bus0_wake,
                      irq_low_voltage, irq_pins_10_15, irq_pins_5_9, irq_pin_direct};

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence s_req;
    req && waitrequest;
  endsequence
  sequence s_ans;
    !waitrequest ##1 waitrequest;
  endsequence

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_BUS_ANSWER: assert property (s_req |=> s_ans)
    else $error("bus answer not one cycle long");
  AST_ANS_CAUSE: assert property (!waitrequest |-> $past(req))
    else $error("answer without request");
  AST_TOP_ZERO: assert property (!waitrequest |-> readdata[31:25] == 7'h00)
    else $error("unused read bits set");
  AST_EVT_ONE: assert property (event_to_core |=> !event_to_core)
    else $error("event longer than one cycle");
  AST_CORE_OR: assert property (event_to_core == |event_lines)
    else $error("core event not the or of channel events");
  AST_EVT_WAKE: assert property (event_to_core |-> wakeup_req)
    else $error("event without wake request");
  AST_IRQ_WAKE: assert property (|irqv |-> wakeup_req)
    else $error("request without wake request");
  // a request may only drop around a committed write (clear or mask change)
  AST_IRQ_HOLD: assert property (!commit && !$past(commit) |=> (irqv & $past(irqv)) == $past(irqv))
    else $error("request dropped without a write");
  AST_PIN_CAUSE: assert property (|event_lines[15:0] |->
      $past(pin_lines, 3) != $past(pin_lines, 4) || $past(commit, 2))
    else $error("pin event without edge or trigger");
  AST_INT_CAUSE: assert property (|event_lines[24:16] |->
      $past(internal_lines, 3) != $past(internal_lines, 4) || $past(commit, 2))
    else $error("internal event without edge or trigger");
endmodule

bind edge_irq_event_unit edge_irq_chk u_chk (.*);

// >>> verification/core_model.sv
// sleeping processor model that watches the unit's event and wake lines
// assumes the same clock and reset as the unit
`timescale 1ns/1ps

module core_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic event_to_core,
  input wire logic wakeup_req,
  output int evt_count,
  output logic woke
);
  // each single-cycle pulse counts once, so a stretched pulse shows up as extra events
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      evt_count <= 0;
      woke <= 1'b0;
    end else begin
      if (event_to_core) evt_count <= evt_count + 1;
      if (wakeup_req) woke <= 1'b1;
    end
  end
endmodule

// >>> verification/edge_irq_event_unit_tb.sv
// self-checking bench for the edge interrupt and event unit
// assumes the checker binds itself and core_model stands for the processor
`timescale 1ns/1ps

module edge_irq_event_unit_tb import edge_irq_pkg::*; ;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] address = '0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [DATA_W-1:0] writedata = '0;
  logic [3:0] byteenable = FULL_WORD_BE;
  logic [DATA_W-1:0] readdata;
  logic waitrequest;
  logic [24:0] lv = '0;
  wire [NUM_PIN_LINES-1:0] pin_lines = lv[15:0];
  wire [NUM_INT_LINES-1:0] internal_lines = lv[24:16];
  logic [NUM_DIRECT_PIN_IRQ-1:0] irq_pin_direct;
  logic irq_pins_5_9, irq_pins_10_15, irq_low_voltage, irq_bus0_wake, irq_bus1_wake;
  logic irq_comparator, irq_over_voltage, event_to_core, wakeup_req, woke;
  logic [NUM_LINES-1:0] event_lines;
  int evt_count;
  int fail_count = 0;
  int n_checks = 0;
  wire [11:0] irqv = {irq_over_voltage, irq_comparator, irq_bus1_wake, irq_bus0_wake,
                      irq_low_voltage, irq_pins_10_15, irq_pins_5_9, irq_pin_direct};

  edge_irq_event_unit u_dut (.*);
  core_model u_core (.*);

  // ----------------------------------------------------------------
  // common tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // request held until waitrequest is sampled low, then released
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    // no local limit: a slave that never answers is caught by the watchdog
    do begin
      @(posedge clock);
    end while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, '0, q);
    chk(q, e);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    for (int a = 0; a < 28; a += 4) begin
      rdc(8'(a), 32'h0);
    end
    for (int a = 0; a < 20; a += 4) begin
      wr(8'(a), 32'hffffffff);
      rdc(8'(a), 32'h01ffffff);
      wr(8'(a), 32'h0);
    end
    byteenable <= 4'h3;
    wr(OFS_IRQ_MASK, 32'h1);
    byteenable <= FULL_WORD_BE;
    rdc(OFS_IRQ_MASK, 32'h0);
    wr(8'h18, 32'hffffffff);
    rdc(8'h18, 32'h0);
  endtask

  task automatic t_soft();
    int ch[12] = '{0, 4, 5, 9, 10, 15, 16, 17, 18, 19, 20, 24};
    logic [11:0] ex[12] = '{12'h001, 12'h010, 12'h020, 12'h020, 12'h040, 12'h040,
                            12'h080, 12'h000, 12'h100, 12'h200, 12'h400, 12'h800};
    for (int i = 0; i < 12; i++) begin
      wr(OFS_IRQ_MASK, 32'h1 << ch[i]);
      wr(OFS_SOFT_TRIG, 32'h1 << ch[i]);
      repeat (2) @(posedge clock);
      chk(32'(irqv), 32'(ex[i]));
      wr(OFS_PENDING, 32'h0);
      rdc(OFS_PENDING, 32'h1 << ch[i]);
      chk(32'(irqv), 32'(ex[i]));
      wr(OFS_PENDING, 32'h1 << ch[i]);
      @(posedge clock);
      chk(32'(irqv), 32'h0);
    end
    wr(OFS_SOFT_TRIG, 32'h0);
    rdc(OFS_SOFT_TRIG, 32'h0);
  endtask

  task automatic t_evt();
    int c0;
    wr(OFS_IRQ_MASK, 32'h0);
    wr(OFS_EVT_MASK, 32'h01ffffff);
    c0 = evt_count;
    wr(OFS_SOFT_TRIG, 32'h1 << CH_RTC_ALARM);
    repeat (2) @(posedge clock);
    chk(32'(event_lines), 32'h1 << CH_RTC_ALARM);
    chk(32'(wakeup_req), 32'h1);
    @(posedge clock);
    chk(32'(event_lines), 32'h0);
    chk(32'(wakeup_req), 32'h0);
    chk(evt_count - c0, 1);
    chk(32'(woke), 32'h1);
    rdc(OFS_PENDING, 32'h0);
  endtask

  // modes 1 rise, 2 fall, 3 both; each line change must match the mode
  task automatic t_edges(input int c);
    logic [31:0] e;
    wr(OFS_IRQ_MASK, 32'h1 << c);
    for (int m = 1; m < 4; m++) begin
      wr(OFS_RISE_EN, 32'(m % 2) << c);
      wr(OFS_FALL_EN, 32'(m / 2) << c);
      for (int v = 1; v >= 0; v--) begin
        @(posedge clock);
        lv[c] <= v[0];
        // two sync stages plus the event register: the pulse stands after the third edge
        repeat (4) @(posedge clock);
        e = (v == 1 ? 32'(m % 2) : 32'(m / 2)) << c;
        chk(32'(event_lines), e);
        rdc(OFS_PENDING, e);
        wr(OFS_PENDING, e);
      end
    end
  endtask

  task automatic t_indep();
    wr(OFS_EVT_MASK, 32'h0);
    wr(OFS_RISE_EN, 32'h000000c0);
    wr(OFS_FALL_EN, 32'h0);
    wr(OFS_IRQ_MASK, 32'h00000040);
    @(posedge clock);
    lv[7:6] <= 2'b11;
    repeat (5) @(posedge clock);
    chk(32'(irqv), 32'h020);
    rdc(OFS_PENDING, 32'h40);
    wr(OFS_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clock);
    chk(32'(irqv), 32'h0);
    rdc(OFS_PENDING, 32'h40);
    wr(OFS_PENDING, 32'h40);
    rdc(OFS_PENDING, 32'h0);
  endtask

  // ----------------------------------------------------------------
  // clock, sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    forever #20 clock = ~clock;
  end

  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_regs();
    t_soft();
    t_evt();
    t_edges(2);
    t_edges(21);
    t_indep();
    test_done();
  end

  // the whole run needs well under two thousand cycles
  initial begin
    #400000;
    fail_count++;
    test_done();
  end
endmodule
